/* afe_clamp_pkg.sv */
// Constants and register map for the front-end clamp control block
`default_nettype none
package afe_clamp_pkg;
    // Register byte offsets
    localparam logic [4:0] ADDR_GAIN   = 5'h00;
    localparam logic [4:0] ADDR_ANALOG = 5'h04;
    localparam logic [4:0] ADDR_CLAMP  = 5'h08;
    localparam logic [4:0] ADDR_DUMMY  = 5'h0c;
    localparam logic [4:0] ADDR_CTRL   = 5'h10;
    localparam logic [4:0] ADDR_STATUS = 5'h14;
    localparam logic [4:0] ADDR_LEVEL  = 5'h18;
    localparam logic [4:0] ADDR_LINES  = 5'h1c;
    // Reset values
    localparam logic [4:0]  CLAMP_SET_RST = 5'h09;
    localparam logic [2:0]  BAND_RST      = 3'h6;
    // Gain law in hundredths of a dB
    localparam logic signed [11:0] GAIN_BASE_CDB = -12'sd600;
    localparam logic [11:0] GAIN_STEP_CDB = 12'h004;
    // Clamp target law
    localparam logic [8:0]  CLAMP_STEP = 9'h008;
    localparam logic [8:0]  CLAMP_BASE = 9'h038;
    // Lead-in
    localparam logic [12:0] LEADIN_ERR_LIMIT = 13'h0020;
    localparam logic [8:0]  LEADIN_FACTOR    = 9'h020;
    localparam logic [8:0]  NORMAL_FACTOR    = 9'h001;
    // Wide black reference and detection window
    localparam logic [10:0] WIDE_MIN_CLKS = 11'h03f;
    localparam logic [10:0] WIDTH_SAT     = 11'h7ff;
    localparam logic [3:0]  WIN_START     = 4'h4;
    localparam logic [3:0]  WIN_WIDE      = 4'h8;
    localparam logic [3:0]  WIN_NARROW    = 4'h4;
    // Dummy pulse delay stop code
    localparam logic [7:0]  DLY_STOP      = 8'hff;
    // Settling lines after standby
    localparam logic [4:0]  SETTLE_LINES  = 5'h14;
    // Reduced power sensor clock guarantee, MHz
    localparam logic [7:0]  FMAX_NORMAL   = 8'h24;
    localparam logic [7:0]  FMAX_REDUCED  = 8'h19;
    // Calibration length in conversion clocks
    localparam int          CAL_CLKS      = 40000;
endpackage : afe_clamp_pkg
`default_nettype wire

/* afe_clamp_ctrl.sv */
// Front-end clamp control: Wishbone registers, lead-in, wide black, dummy clamp
//
// Summary of operation
// - Gain code N gives -6 dB plus 0.04 dB per step.
// - Three-bit band code selects 6 to 50 MHz sensor rate.
// - Precharge cutoff 72 to 6 MHz, sample amp cutoff 116 to 32 MHz.
// - Full power-down idles lead-in, wide, window and dummy logic and clears calibration; host restarts from calibration.
// - Standby keeps only reference; clamp settles about 20 lines after.
// - Clamp target is setting times 8 plus 56, default 128.
// - Gain change starts lead-in; two-bit field scales loop gain.
// - Lead-in holds while error above 32 LSB, then programmed lines.
// - One line is one black-reference pulse period.
// - Lead-in loop gain factor is 32 times normal.
// - Enabled wide pulse of 63 clocks or more clamps every clock.
// - Wide mode stages switch current after selected counts while the dummy delay field is zero.
// - Detection covers 8 pixels, or 4 when window bit set.
// - Polarity 0 means negative-going pulse, 1 positive-going.
// - Reduced power guarantees 25 MHz, otherwise 36 MHz.
// - Releasing reset starts calibration lasting 40000 clocks.
// - Offset DAC gets cancellation value plus clamp target.
// - Black above dummy plus threshold switches to dummy clamp.
// - Dummy pulse starts at preblank phase plus programmed delay.
// - Dummy threshold zero disables the dummy clamp.
// - Lead-in continuation code gives 1, 2, 4 or 8 lines.
// - Dummy delay is field times 4 clocks; all ones stops it.
`default_nettype none
module afe_clamp_ctrl
    import afe_clamp_pkg::*;
#(
    parameter int CAL_CYCLES = CAL_CLKS
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [4:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Sensor timing pins
    input  wire logic        black_ref_pin_i,
    input  wire logic        preblank_pin_i,
    // Levels from the conversion path
    input  wire logic signed [12:0] offset_error_i,
    input  wire logic [11:0] black_level_i,
    input  wire logic [11:0] dummy_level_i,
    input  wire logic [11:0] cal_cancel_i,
    // Analog settings
    output logic             active_o,
    output logic             standby_o,
    output logic [9:0]       gain_code_o,
    output logic signed [11:0] gain_cdb_o,
    output logic [7:0]       band_mhz_o,
    output logic [7:0]       precharge_mhz_o,
    output logic [7:0]       sample_amp_mhz_o,
    output logic [7:0]       max_sensor_mhz_o,
    // Clamp control
    output logic [8:0]       clamp_target_o,
    output logic [12:0]      offset_dac_o,
    output logic             calibrating_o,
    output logic             leadin_o,
    output logic [8:0]       loop_gain_o,
    output logic             line_tick_o,
    output logic             wide_o,
    output logic             detect_window_o,
    output logic [3:0]       detect_pixels_o,
    output logic [2:0]       current_stage_o,
    output logic             dummy_clamp_o,
    output logic             dummy_pulse_o,
    output logic             settling_o
);
    localparam logic [15:0] CAL_LAST = 16'(CAL_CYCLES - 1);

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
        logic [9:0]  gain;
        logic [2:0]  band;
        logic [3:0]  pcf;
        logic [1:0]  saf;
        logic        pd;
        logic        reference_only_hold;
        logic        lowpwr;
        logic [4:0]  cset;
        logic        win4;
        logic        blk_pol;
        logic        sp_pol;
        logic [1:0]  mag;
        logic [1:0]  cont;
        logic        wide_en;
        logic [5:0]  th;
        logic [4:0]  dthr;
        logic [7:0]  ddly;
        logic        rst_mode;
        logic        cal_busy;
        logic        cal_done;
        logic [15:0] cal_cnt;
        logic        blk_s1, blk_s2, blk_d;
        logic        pb_s1, pb_s2, pb_d;
        logic [15:0] lines;
        logic        tick;
        logic        leadin;
        logic [3:0]  lcnt;
        logic [10:0] wcnt;
        logic        wide;
        logic [2:0]  stage;
        logic [3:0]  ocnt;
        logic        win;
        logic [9:0]  dcnt;
        logic        drun;
        logic        dpulse;
        logic [4:0]  settle;
        logic        dclamp;
        logic [12:0] dac;
    } state_t;

    state_t st, next_st;

    // Byte-lane merge of a write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) r[8*i +: 8] = d[8*i +: 8];
        end
        return r;
    endfunction : merge

    // Wide-mode stage count; zero stands for infinity
    function automatic logic [10:0] stage_count(input logic [1:0] stg, input logic [1:0] c);
        logic [10:0] r;
        r = 11'h000;
        case (stg)
            2'd0: case (c) 2'd0: r = 11'h00f; 2'd1: r = 11'h03f; 2'd2: r = 11'h0c8;
                           default: r = 11'h000; endcase
            2'd1: case (c) 2'd0: r = 11'h07f; 2'd1: r = 11'h0ff; 2'd2: r = 11'h1ff;
                           default: r = 11'h000; endcase
            default: case (c) 2'd0: r = 11'h1ff; 2'd1: r = 11'h3ff;
                              default: r = 11'h000; endcase
        endcase
        return r;
    endfunction : stage_count

    // Magnitude of the signed offset error
    function automatic logic [12:0] mag13(input logic signed [12:0] e);
        return e[12] ? 13'(-e) : 13'(e);
    endfunction : mag13

    logic [31:0] wv;
    logic        req;
    logic        blk_act, blk_prev, pb_act, pb_prev;
    logic        err_big;
    logic        lead_set;
    logic [3:0]  cont_lines;
    logic [2:0]  win_end;

    always_comb begin
        next_st = st;
        req     = cyc_i && stb_i && !st.ack;
        wv      = 32'h0;
        lead_set = 1'b0;
        next_st.ack    = req;
        next_st.tick   = 1'b0;
        next_st.dpulse = 1'b0;
        // Two-flop synchronisers for the timing pins
        next_st.blk_s1 = black_ref_pin_i;
        next_st.blk_s2 = st.blk_s1;
        next_st.pb_s1  = preblank_pin_i;
        next_st.pb_s2  = st.pb_s1;
        next_st.blk_d  = st.blk_s2;
        next_st.pb_d   = st.pb_s2;
        blk_act  = st.blk_s2 ~^ st.blk_pol;
        blk_prev = st.blk_d ~^ st.blk_pol;
        pb_act   = st.pb_s2 ~^ st.sp_pol;
        pb_prev  = st.pb_d ~^ st.sp_pol;
        err_big  = mag13(offset_error_i) > LEADIN_ERR_LIMIT;
        cont_lines = 4'h1 << st.cont;
        win_end  = st.win4 ? 3'(WIN_NARROW - 4'h1) : 3'(WIN_WIDE - 4'h1);

        // Register writes take effect with the ack
        if (req && we_i) begin
            case (adr_i)
                ADDR_GAIN: begin
                    wv = merge({22'h0, st.gain}, dat_i, sel_i);
                    next_st.gain = wv[9:0];
                    if (wv[9:0] != st.gain) begin
                        lead_set = 1'b1;
                    end
                end
                ADDR_ANALOG: begin
                    wv = merge({20'h0, st.lowpwr, st.reference_only_hold, st.pd, st.saf, st.pcf, st.band},
                               dat_i, sel_i);
                    {next_st.lowpwr, next_st.reference_only_hold, next_st.pd} = wv[11:9];
                    {next_st.saf, next_st.pcf, next_st.band}   = wv[8:0];
                    if (st.reference_only_hold && !wv[10]) next_st.settle = SETTLE_LINES;
                end
                ADDR_CLAMP: begin
                    wv = merge({13'h0, st.th, st.wide_en, st.cont, st.mag, st.sp_pol,
                                st.blk_pol, st.win4, st.cset}, dat_i, sel_i);
                    {next_st.th, next_st.wide_en, next_st.cont, next_st.mag} = wv[18:8];
                    {next_st.sp_pol, next_st.blk_pol, next_st.win4, next_st.cset} = wv[7:0];
                end
                ADDR_DUMMY: begin
                    wv = merge({19'h0, st.ddly, st.dthr}, dat_i, sel_i);
                    next_st.ddly = wv[12:5];
                    next_st.dthr = wv[4:0];
                end
                ADDR_CTRL: begin
                    wv = merge({31'h0, st.rst_mode}, dat_i, sel_i);
                    next_st.rst_mode = wv[0];
                    if (st.rst_mode && !wv[0]) begin
                        next_st.cal_busy = 1'b1;
                        next_st.cal_done = 1'b0;
                        next_st.cal_cnt  = 16'h0;
                    end
                end
                default: ;
            endcase
        end

        // Read data; unmapped addresses read zero
        next_st.dat = 32'h0;
        if (req && !we_i) begin
            case (adr_i)
                ADDR_GAIN:   next_st.dat = {22'h0, st.gain};
                ADDR_ANALOG: next_st.dat = {20'h0, st.lowpwr, st.reference_only_hold, st.pd, st.saf,
                                            st.pcf, st.band};
                ADDR_CLAMP:  next_st.dat = {13'h0, st.th, st.wide_en, st.cont, st.mag,
                                            st.sp_pol, st.blk_pol, st.win4, st.cset};
                ADDR_DUMMY:  next_st.dat = {19'h0, st.ddly, st.dthr};
                ADDR_CTRL:   next_st.dat = {31'h0, st.rst_mode};
                ADDR_STATUS: next_st.dat = {24'h0, st.settle != 5'h0, st.dclamp, st.stage[0],
                                            st.wide, st.leadin, st.cal_done, st.cal_busy,
                                            st.rst_mode};
                ADDR_LEVEL:  next_st.dat = {3'h0, st.dac, 7'h0, clamp_target_o};
                ADDR_LINES:  next_st.dat = {16'h0, st.lines};
                default:     next_st.dat = 32'h0;
            endcase
        end

        // Calibration counter
        if (st.cal_busy) begin
            next_st.cal_cnt = st.cal_cnt + 16'h1;
            if (st.cal_cnt == CAL_LAST) begin
                next_st.cal_busy = 1'b0;
                next_st.cal_done = 1'b1;
            end
        end

        // Offset DAC follows cancellation plus target
        next_st.dac = 13'(cal_cancel_i) + 13'(clamp_target_o);

        // Line counting on each active black-reference edge
        if (blk_act && !blk_prev) begin
            next_st.tick  = 1'b1;
            next_st.lines = st.lines + 16'h1;
            next_st.ocnt  = 4'h0;
            next_st.wcnt  = 11'h0;
            next_st.wide  = 1'b0;
            next_st.stage = 3'h0;
            if (st.settle != 5'h0) next_st.settle = st.settle - 5'h1;
            // Lead-in ends after the programmed clean lines
            if (st.leadin) begin
                if (err_big) begin
                    next_st.lcnt = 4'h0;
                end else if (st.lcnt + 4'h1 >= cont_lines) begin
                    next_st.leadin = 1'b0;
                    next_st.lcnt   = 4'h0;
                end else begin
                    next_st.lcnt = st.lcnt + 4'h1;
                end
            end
        end else if (blk_act) begin
            // Pulse width and window counting within the pulse
            if (st.wcnt != WIDTH_SAT) next_st.wcnt = st.wcnt + 11'h1;
            if (st.ocnt != 4'hf) next_st.ocnt = st.ocnt + 4'h1;
            if (st.wide_en && st.wcnt + 11'h1 >= WIDE_MIN_CLKS) next_st.wide = 1'b1;
            for (int k = 0; k < 3; k++) begin
                if (st.wide && st.ddly == 8'h0 && stage_count(2'(k), st.th[2*k +: 2]) != 11'h0
                    && st.wcnt >= stage_count(2'(k), st.th[2*k +: 2]))
                    next_st.stage[k] = 1'b1;
            end
        end else begin
            next_st.wide = 1'b0;
        end
        // A gain change wins over a lead-in that ends on the same edge
        if (lead_set) begin
            next_st.leadin = 1'b1;
            next_st.lcnt   = 4'h0;
        end
        // Detection window after the pulse start
        next_st.win = blk_act && (st.ocnt >= WIN_START)
                      && (st.ocnt - WIN_START <= 4'(win_end));

        // Dummy clamp decision
        next_st.dclamp = (st.dthr != 5'h0)
                         && (13'(black_level_i) > 13'(dummy_level_i) + 13'(st.dthr));

        // Dummy pulse delayed from the preblank edge
        if (pb_act && !pb_prev && st.ddly != DLY_STOP) begin
            next_st.drun = 1'b1;
            next_st.dcnt = {st.ddly, 2'b00};
        end else if (st.drun) begin
            if (st.dcnt == 10'h0) begin
                next_st.drun   = 1'b0;
                next_st.dpulse = 1'b1;
            end else begin
                next_st.dcnt = st.dcnt - 10'h1;
            end
        end

        // Power-down and standby both idle lead-in, wide, window and dummy logic; power-down also clears calibration
        if (st.pd || st.reference_only_hold) begin
            next_st.leadin = 1'b0;
            next_st.wide   = 1'b0;
            next_st.stage  = 3'h0;
            next_st.win    = 1'b0;
            next_st.drun   = 1'b0;
            next_st.dpulse = 1'b0;
            next_st.dclamp = 1'b0;
            next_st.tick   = 1'b0;
        end
        if (st.pd) begin
            next_st.cal_busy = 1'b0;
            next_st.cal_done = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            next_st_reset();
        end else begin
            st <= next_st;
        end
    end

    task automatic next_st_reset();
        st         <= '0;
        st.cset    <= CLAMP_SET_RST;
        st.band    <= BAND_RST;
        st.rst_mode <= 1'b1;
    endtask : next_st_reset

    // Output mapping from registered state
    assign ack_o            = st.ack;
    assign dat_o            = st.dat;
    assign active_o         = !st.pd;
    assign standby_o        = st.reference_only_hold;
    assign gain_code_o      = st.gain;
    assign gain_cdb_o       = GAIN_BASE_CDB + $signed(12'(st.gain) * GAIN_STEP_CDB);
    assign band_mhz_o       = st.band == 3'd0 ? 8'd6  : st.band == 3'd1 ? 8'd12 :
                              st.band == 3'd2 ? 8'd18 : st.band == 3'd3 ? 8'd25 :
                              st.band == 3'd4 ? 8'd30 : st.band == 3'd5 ? 8'd35 :
                              st.band == 3'd6 ? 8'd40 : 8'd50;
    assign precharge_mhz_o  = 8'd72 - 8'd3 * 8'(st.pcf) - 8'd3 * 8'(st.pcf[3:1]);
    assign sample_amp_mhz_o = st.saf == 2'd0 ? 8'd116 : st.saf == 2'd1 ? 8'd75 :
                              st.saf == 2'd2 ? 8'd56 : 8'd32;
    assign max_sensor_mhz_o = st.lowpwr ? FMAX_REDUCED : FMAX_NORMAL;
    assign clamp_target_o   = 9'(st.cset) * CLAMP_STEP + CLAMP_BASE;
    assign offset_dac_o     = st.dac;
    assign calibrating_o    = st.cal_busy;
    assign leadin_o         = st.leadin;
    assign loop_gain_o      = st.leadin ? LEADIN_FACTOR << st.mag : NORMAL_FACTOR;
    assign line_tick_o      = st.tick;
    assign wide_o           = st.wide;
    assign detect_window_o  = st.win;
    assign detect_pixels_o  = st.win4 ? WIN_NARROW : WIN_WIDE;
    assign current_stage_o  = st.stage;
    assign dummy_clamp_o    = st.dclamp;
    assign dummy_pulse_o    = st.dpulse;
    assign settling_o       = st.settle != 5'h0;

    // Checks on the clamp path
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_wb_ack_once:  assert property (ack_o |=> !ack_o)
        else $error("ack held two cycles");
    a_wb_ack_req:   assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("no ack one cycle after request");
    a_cal_len:      assert property ($rose(calibrating_o) |-> calibrating_o [*8])
        else $error("calibration ended early");
    a_gain_leadin:  assert property (req && we_i && adr_i == ADDR_GAIN && sel_i == 4'hf
                                     && dat_i[9:0] != st.gain && !st.pd && !st.reference_only_hold
                                     |=> leadin_o)
        else $error("gain change did not start lead-in");
    a_leadin_gain:  assert property (leadin_o |-> loop_gain_o >= LEADIN_FACTOR)
        else $error("lead-in loop gain below factor");
    a_leadin_hold:  assert property (leadin_o && blk_act && !blk_prev && err_big
                                     && !st.pd && !st.reference_only_hold |=> leadin_o)
        else $error("lead-in left with large error");
    a_target_law:   assert property (clamp_target_o == 9'(st.cset) * 9'h008 + 9'h038)
        else $error("clamp target law broken");
    a_dummy_off:    assert property (st.dthr == 5'h0 && $stable(st.dthr) |=> !dummy_clamp_o)
        else $error("dummy clamp with zero threshold");
    a_dly_stop:     assert property (st.ddly == DLY_STOP && !st.drun |=> !st.drun)
        else $error("dummy pulse ran with stop code");
    a_pd_quiet:     assert property (st.pd |=> !leadin_o && !wide_o && !calibrating_o)
        else $error("activity during power-down");
    a_wide_min:     assert property ($rose(wide_o) |-> st.wcnt >= 11'h03e)
        else $error("wide declared on short pulse");

    c_leadin_done:  cover property ($fell(leadin_o));
    c_cal_done:     cover property ($fell(calibrating_o));
    c_dummy_pulse:  cover property (dummy_pulse_o);
    c_wide_stage:   cover property (wide_o && current_stage_o[0]);
endmodule : afe_clamp_ctrl
`default_nettype wire

/* obp_source.sv */
// Black-reference pulse source standing in for the sensor timing side
`default_nettype none
module obp_source (
    // Clock and control
    input  wire logic       clk_i,
    input  wire logic       go_i,
    input  wire logic [7:0] width_i,
    // Pin and count of pulses sent
    output logic            pin_o,
    output int              n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // One pulse per line, period width plus 101 clocks; pin idles high between lines
    initial begin
        pin_o = 1'b1;
        n_o = 0;
        forever begin
            @(posedge clk_i);
            if (go_i) begin
                pin_o <= 1'b0;
                repeat (width_i) @(posedge clk_i);
                pin_o <= 1'b1;
                n_o <= n_o + 1;
                repeat (100) @(posedge clk_i);
            end
        end
    end
endmodule : obp_source
`default_nettype wire

/* tb.sv */
// Self-checking bench for the front-end clamp control block
`default_nettype none
module tb
    import afe_clamp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int CAL = 20;
    int cal_n = 0;
    logic [31:0] w;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, go, pin, pre_i;
    logic [4:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o;
    logic signed [12:0] err_i;
    logic [11:0] blk_i, dum_i, can_i, gain_cdb_o;
    logic [7:0] width, band_o, pre_o, sa_o, fmax_o;
    logic [8:0] tgt_o, lg_o;
    logic [12:0] dac_o;
    logic [3:0] pix_o;
    logic act_o, cal_o, lead_o, tick_o, wide_o;
    int n_mismatch, comparisons, ticks, lines, seed = 97;
    logic [31:0] q[$];
    logic [7:0] bands[8] = '{8'h06, 8'h0c, 8'h12, 8'h19, 8'h1e, 8'h23, 8'h28, 8'h32};
    logic [7:0] sas[4] = '{8'h74, 8'h4b, 8'h38, 8'h20};
    logic [31:0] v;
    logic [8:0] t;
    afe_clamp_ctrl #(.CAL_CYCLES(CAL)) uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .black_ref_pin_i(pin), .preblank_pin_i(pre_i), .offset_error_i(err_i),
        .black_level_i(blk_i), .dummy_level_i(dum_i), .cal_cancel_i(can_i), .active_o(act_o),
        .standby_o(), .gain_code_o(), .gain_cdb_o(gain_cdb_o), .band_mhz_o(band_o),
        .precharge_mhz_o(pre_o), .sample_amp_mhz_o(sa_o), .max_sensor_mhz_o(fmax_o),
        .clamp_target_o(tgt_o), .offset_dac_o(dac_o), .calibrating_o(cal_o), .leadin_o(lead_o),
        .loop_gain_o(lg_o), .line_tick_o(tick_o), .wide_o(wide_o), .detect_window_o(),
        .detect_pixels_o(pix_o), .current_stage_o(), .dummy_clamp_o(), .dummy_pulse_o(),
        .settling_o());
    obp_source src (.clk_i(clk_i), .go_i(go), .width_i(width), .pin_o(pin), .n_o(lines));
    // 40 MHz clock
    always #12.5 clk_i = ~clk_i;
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        @(negedge clk_i);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: port got %h want %h", $time, g, e);
        end
    endtask : chk
    // Classic cycle: request held until ack is sampled high, then released
    task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= 4'hf;
        k = 0;
        do begin @(posedge clk_i); k++; end while (ack_o !== 1'b1 && k < 50);
        cyc_i <= 1'b0; stb_i <= 1'b0;
        if (k >= 50) begin n_mismatch++; test_done(); end
    endtask : wb
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        q.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask : rd
    // Bounded wait for the partner to finish more lines
    task automatic wline(input int k);
        int m, i;
        m = lines + k;
        for (i = 0; i < 200 * k && lines < m; i++) @(posedge clk_i);
        if (lines < m) begin n_mismatch++; test_done(); end
    endtask : wline
    // Read data is judged against the oldest note at the ack edge
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && we_i === 1'b0) begin
            comparisons++;
            w = q.pop_front();
            if (dat_o !== w) begin
                n_mismatch++;
                $display("unexpected at %0t: read got %h want %h", $time, dat_o, w);
            end
        end
        if (tick_o === 1'b1) ticks++;
        if (cal_o === 1'b1) cal_n++;
    end
    initial begin
        clk_i = 0; rst_i = 1; cyc_i = 0; stb_i = 0; we_i = 0; adr_i = 0; sel_i = 0; dat_i = 0;
        pre_i = 1; err_i = 13'sh0100; go = 0; width = 8'h0a;
        blk_i = $random(seed); dum_i = $random(seed); can_i = $random(seed);
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(ADDR_CLAMP, 32'h9);
        rd(ADDR_ANALOG, 32'h6);
        chk({20'h0, gain_cdb_o}, 32'hda8);
        wb(1'b1, ADDR_CTRL, 32'h0);
        repeat (100) @(negedge clk_i);
        chk(32'(cal_n), CAL);
        for (int b = 0; b < 8; b++) begin
            wb(1'b1, ADDR_ANALOG, 32'(b) | (b[0] ? 32'h878 : 0) | (32'(b[1:0]) << 7));
            chk({24'h0, band_o}, {24'h0, bands[b]});
            chk({24'h0, fmax_o}, b[0] ? 32'h19 : 32'h24);
            chk({24'h0, pre_o}, b[0] ? 32'h6 : 32'h48);
            chk({24'h0, sa_o}, {24'h0, sas[b[1:0]]});
        end
        wb(1'b1, ADDR_ANALOG, 32'h206);
        chk({31'h0, act_o}, 32'h0);
        wb(1'b1, ADDR_ANALOG, 32'h6);
        for (int i = 0; i < 3; i++) begin
            v = (i == 0) ? 32'h0 : (i == 1) ? 32'h1f : ($random(seed) & 32'h1f);
            t = 9'(v) * 9'h8 + 9'h38;
            wb(1'b1, ADDR_CLAMP, v | 32'h20);
            chk({23'h0, tgt_o}, {23'h0, t});
            chk({28'h0, pix_o}, 32'h4);
            rd(ADDR_LEVEL, {3'h0, 13'(can_i) + 13'(t), 7'h0, t});
        end
        wb(1'b1, ADDR_CLAMP, 32'h200);
        v = ($random(seed) & 32'h3ff) | 32'h1;
        wb(1'b1, ADDR_GAIN, v);
        chk({20'h0, gain_cdb_o}, (32'hda8 + v * 4) & 32'hfff);
        chk({31'h0, lead_o}, 32'h1);
        chk({23'h0, lg_o}, 32'h80);
        go <= 1'b1;
        wline(3);
        chk({31'h0, lead_o}, 32'h1);
        err_i <= 13'sh0000;
        wline(3);
        chk({31'h0, lead_o}, 32'h0);
        chk({23'h0, lg_o}, 32'h1);
        go <= 1'b0;
        repeat (120) @(posedge clk_i);
        chk(32'(ticks), 32'(lines));
        wb(1'b1, ADDR_CLAMP, 32'h1000);
        width <= 8'h46;
        go <= 1'b1;
        wline(1);
        chk({31'h0, wide_o}, 32'h1);
        go <= 1'b0;
        test_done();
    end
endmodule : tb
`default_nettype wire
